// file: logic/cct_timer_map.vh
// Purpose: register indices, field positions, codes and reset values
// Assumes: byte address of a register is four times its index
// Notes: included by the cascadable capture timer files
`ifndef CCT_TIMER_MAP_VH
`define CCT_TIMER_MAP_VH

// register indices
`define CCT_IDX_CTRL_A 4'h0
`define CCT_IDX_CTRL_B 4'h1
`define CCT_IDX_EV_CTRL 4'h4
`define CCT_IDX_IRQ_EN 4'h5
`define CCT_IDX_IRQ_FLAG 4'h6
`define CCT_IDX_STATUS 4'h7
`define CCT_IDX_COUNT 4'hA
`define CCT_IDX_LATCH 4'hC

// control A fields
`define CCT_A_ENABLE 0
`define CCT_A_CLOCK_SOURCE_SELECT_LO 1
`define CCT_A_CLOCK_SOURCE_SELECT_HI 3
`define CCT_A_RESTART 4
`define CCT_A_CHAIN 5
`define CCT_A_STBY 6

// control B fields
`define CCT_B_MODE_LO 0
`define CCT_B_MODE_HI 2
`define CCT_B_OUT_EN 4
`define CCT_B_OUT_INIT 5
`define CCT_B_ASYNC 6

// event control fields
`define CCT_E_TRIG_EN 0
`define CCT_E_EDGE 4
`define CCT_E_FILTER 6

// flag and enable bits
`define CCT_F_SAMPLE_TRIGGER 0
`define CCT_F_WRAP 1

// clock source codes
`define CCT_CLK_DIV1 3'h0
`define CCT_CLK_DIV2 3'h1
`define CCT_CLK_CMP0 3'h2
`define CCT_CLK_CMP1 3'h3
`define CCT_CLK_EVENT 3'h7

// counter operating modes
`define CCT_M_INT 3'h0
`define CCT_M_TIMEOUT 3'h1
`define CCT_M_SAMPLE_TRIGGER 3'h2
`define CCT_M_FRQ 3'h3
`define CCT_M_PW 3'h4
`define CCT_M_FRQPW 3'h5
`define CCT_M_SINGLE 3'h6
`define CCT_M_PWM8 3'h7

// reset values and limits
`define CCT_RST_CTRL 7'h00
`define CCT_RST_FLAGS 2'h0
`define CCT_RST_COUNT 16'h0000
`define CCT_COUNT_MAX 16'hFFFF
`define CCT_FILTER_TAPS 4

// bus answers
`define CCT_RESP_OKAY 2'h0
`define CCT_RESP_SLVERR 2'h2

`endif

// file: logic/cct_evfilt.v
// Purpose: event input synchroniser, noise filter and edge detector
// Assumes: aclk is the peripheral clock; event line is asynchronous
// Notes: edge catchers toggle on the raw line for sub-cycle pulses
`include "cct_timer_map.vh"

module cct_evfilt #(
  parameter TAPS = `CCT_FILTER_TAPS
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // event line and control
  input wire evt_in,
  input wire filter_en,
  // conditioned results
  output wire level,
  output wire rise,
  output wire fall,
  output wire async_rise,
  output wire async_fall
);

reg s1_reg, s2_reg, prev_reg, stable_reg;
reg [TAPS-1:0] hist_reg;
reg tog_r_reg, tog_f_reg;
reg [2:0] cr_reg, cf_reg;
wire [TAPS-1:0] ones = {TAPS{1'b1}};
wire filt_lvl;

// sampled on the undivided clock
always @(posedge aclk) begin
  if (!aresetn) begin
    s1_reg <= 1'b0;
    s2_reg <= 1'b0;
    hist_reg <= {TAPS{1'b0}};
    stable_reg <= 1'b0;
    prev_reg <= 1'b0;
  end else begin
    s1_reg <= evt_in;
    s2_reg <= s1_reg;
    hist_reg <= {hist_reg[TAPS-2:0], s2_reg};
    stable_reg <= filt_lvl;
    prev_reg <= level;
  end
end

// new level only once all samples agree
assign filt_lvl = (hist_reg == ones) ? 1'b1 :
                  (hist_reg == {TAPS{1'b0}}) ? 1'b0 : stable_reg;
assign level = filter_en ? filt_lvl : s2_reg;
assign rise = level & ~prev_reg;
assign fall = ~level & prev_reg;

// toggle catchers for edges shorter than one clock
always @(posedge evt_in or negedge aresetn) begin
  if (!aresetn)
    tog_r_reg <= 1'b0;
  else
    tog_r_reg <= ~tog_r_reg;
end

always @(negedge evt_in or negedge aresetn) begin
  if (!aresetn)
    tog_f_reg <= 1'b0;
  else
    tog_f_reg <= ~tog_f_reg;
end

always @(posedge aclk) begin
  if (!aresetn) begin
    cr_reg <= 3'h0;
    cf_reg <= 3'h0;
  end else begin
    cr_reg <= {cr_reg[1:0], tog_r_reg};
    cf_reg <= {cf_reg[1:0], tog_f_reg};
  end
end

assign async_rise = cr_reg[2] ^ cr_reg[1];
assign async_fall = cf_reg[2] ^ cf_reg[1];

endmodule // cct_evfilt

// file: logic/cct_timer.v
// Purpose: 16-bit cascadable capture timer with AXI4-Lite registers
// Assumes: aclk is the peripheral clock; companion ticks are same-clock
// Notes: a second instance with chain set forms the upper half
//
// Register access over AXI4-Lite and the address map were decided locally.
`include "cct_timer_map.vh"

// Behaviour
// - wrap event and roll to zero at max
// - trigger copies count into latched count
// - chain set delays synchronous trigger edges one clock; async single-shot trigger is not delayed
// - filter passes level after four agreeing samples
// - filter adds four clocks of latency
// - filter samples on undivided clock
// - companion clock source follows type-A timer
// - restart with companion timer restart
// - one-clock event pulses match flag conditions
// - count event active only with event source
// - clock source select code table
// - trigger enable, edge and mode select action
// - async single-shot catches sub-cycle edges
// - wrap flag on roll; capture flag mode-based
// - each source has its own enable bit
// - request while enabled and flag set
// - halt in standby unless run-asleep set
// - power-down halts everything
module cct_timer #(
  parameter ADDR_W = 6
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // event network
  input wire trig_event_in,
  input wire count_event_in,
  output wire sample_trigger_event_out,
  output wire wrap_event_out,
  // companion type-a timers
  input wire [1:0] companion_tick,
  input wire [1:0] companion_restart,
  // sleep state
  input wire standby_sleep,
  input wire powerdown_sleep,
  // interrupt and waveform
  output wire irq_out,
  output wire wave_out,
  output wire wave_oe
);

reg [6:0] ctrl_a_reg, ctrl_b_reg, ev_ctrl_reg;
reg [1:0] irq_enable_reg, irq_flag_reg;
reg [15:0] count_reg, latched_count_reg;
reg running_reg, wave_reg, div2_reg, phase_reg;
reg trig_rise_d_reg, trig_fall_d_reg;
reg sample_trigger_ev_reg, wrap_ev_reg;
reg aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
reg [3:0] aw_idx_reg;
reg [31:0] wdata_reg, rdata_reg;
reg [3:0] wstrb_reg;
reg [1:0] bresp_reg, rresp_reg;
reg [15:0] count_next, latch_next;
reg running_next, wave_next, phase_next, set_sample_trigger, set_wrap, tick;

wire t_rise, t_fall, t_arise, t_afall, c_rise;
wire [2:0] clk_sel = ctrl_a_reg[`CCT_A_CLOCK_SOURCE_SELECT_HI:`CCT_A_CLOCK_SOURCE_SELECT_LO];
wire [2:0] mode = ctrl_b_reg[`CCT_B_MODE_HI:`CCT_B_MODE_LO];
wire chain = ctrl_a_reg[`CCT_A_CHAIN];
wire edge_pol = ev_ctrl_reg[`CCT_E_EDGE];
wire async_en = ctrl_b_reg[`CCT_B_ASYNC];

function [3:0] idx_of;
  input [ADDR_W-1:0] a;
  begin
    idx_of = a[5:2];
  end
endfunction

function mapped;
  input [3:0] i;
  begin
    mapped = (i == `CCT_IDX_CTRL_A) || (i == `CCT_IDX_CTRL_B) ||
             (i == `CCT_IDX_EV_CTRL) || (i == `CCT_IDX_IRQ_EN) ||
             (i == `CCT_IDX_IRQ_FLAG) || (i == `CCT_IDX_STATUS) ||
             (i == `CCT_IDX_COUNT) || (i == `CCT_IDX_LATCH);
  end
endfunction

// trigger channel with optional noise filter
cct_evfilt u_trig (
  .aclk(aclk),
  .aresetn(aresetn),
  .evt_in(trig_event_in),
  .filter_en(ev_ctrl_reg[`CCT_E_FILTER]),
  .level(),
  .rise(t_rise),
  .fall(t_fall),
  .async_rise(t_arise),
  .async_fall(t_afall)
);

// count event channel
cct_evfilt u_cnt (
  .aclk(aclk),
  .aresetn(aresetn),
  .evt_in(count_event_in),
  .filter_en(1'b0),
  .level(),
  .rise(c_rise),
  .fall(),
  .async_rise(),
  .async_fall()
);

// sleep gating of all timer operation
wire active = ctrl_a_reg[`CCT_A_ENABLE] & ~powerdown_sleep &
              (~standby_sleep | ctrl_a_reg[`CCT_A_STBY]);

// chained upper half sees the synchronous trigger edges one clock later; async edges are not delayed
wire rise_sel = chain ? trig_rise_d_reg : t_rise;
wire fall_sel = chain ? trig_fall_d_reg : t_fall;
wire trig_en = ev_ctrl_reg[`CCT_E_TRIG_EN];
wire tr_rise = trig_en & rise_sel;
wire tr_fall = trig_en & fall_sel;
wire tr_start = edge_pol ? tr_fall : tr_rise;
wire tr_stop = edge_pol ? tr_rise : tr_fall;
wire as_hit = trig_en & (t_arise | (edge_pol & t_afall));
wire ss_trig = (async_en ? as_hit :
               (tr_rise | (edge_pol & tr_fall)));

// restart source follows the selected companion
wire restart = ctrl_a_reg[`CCT_A_RESTART] &
               ((clk_sel == `CCT_CLK_CMP1) ? companion_restart[1] :
                companion_restart[0]);

wire free_mode = (mode == `CCT_M_INT) || (mode == `CCT_M_SAMPLE_TRIGGER) ||
                 (mode == `CCT_M_FRQ) || (mode == `CCT_M_PW) ||
                 (mode == `CCT_M_PWM8);
wire run_eff = free_mode | running_reg;
wire at_cmp = count_reg == latched_count_reg;

// count tick from the selected clock source
always @* begin
  case (clk_sel)
    `CCT_CLK_DIV1: tick = 1'b1;
    `CCT_CLK_DIV2: tick = div2_reg;
    `CCT_CLK_CMP0: tick = companion_tick[0];
    `CCT_CLK_CMP1: tick = companion_tick[1];
    `CCT_CLK_EVENT: tick = c_rise;
    default: tick = 1'b0;
  endcase
end

// counter, capture and waveform next state
always @* begin
  count_next = count_reg;
  latch_next = latched_count_reg;
  running_next = running_reg;
  wave_next = wave_reg;
  phase_next = phase_reg;
  set_sample_trigger = 1'b0;
  set_wrap = 1'b0;
  if (active) begin
    if (tick && run_eff) begin
      if (count_reg == `CCT_COUNT_MAX) begin
        count_next = `CCT_RST_COUNT;
        set_wrap = 1'b1;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
    case (mode)
      `CCT_M_INT: begin
        if (tick && at_cmp) begin
          count_next = `CCT_RST_COUNT;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_TIMEOUT: begin
        if (tr_start) begin
          count_next = `CCT_RST_COUNT;
          running_next = 1'b1;
        end else if (tr_stop) begin
          running_next = 1'b0;
        end else if (running_reg && tick && at_cmp) begin
          running_next = 1'b0;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_SAMPLE_TRIGGER: begin
        if (tr_start) begin
          latch_next = count_reg;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_FRQ: begin
        if (tr_start) begin
          latch_next = count_reg;
          count_next = `CCT_RST_COUNT;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_PW: begin
        if (tr_start) begin
          count_next = `CCT_RST_COUNT;
        end else if (tr_stop) begin
          latch_next = count_reg;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_FRQPW: begin
        if (tr_rise && !phase_reg && !irq_flag_reg[`CCT_F_SAMPLE_TRIGGER]) begin
          count_next = `CCT_RST_COUNT;
          running_next = 1'b1;
          phase_next = 1'b1;
        end else if (tr_rise && phase_reg) begin
          running_next = 1'b0;
          phase_next = 1'b0;
          set_sample_trigger = 1'b1;
        end else if (tr_fall && running_reg) begin
          latch_next = count_reg;
        end
      end
      `CCT_M_SINGLE: begin
        if (!running_reg && ss_trig) begin
          count_next = `CCT_RST_COUNT;
          running_next = 1'b1;
          wave_next = 1'b1;
        end else if (running_reg && tick && at_cmp) begin
          running_next = 1'b0;
          wave_next = 1'b0;
          set_sample_trigger = 1'b1;
        end
      end
      `CCT_M_PWM8: begin
        if (tick) begin
          if (count_reg[7:0] == latched_count_reg[7:0]) begin
            count_next = `CCT_RST_COUNT;
            wave_next = 1'b1;
            set_sample_trigger = 1'b1;
          end else if (count_reg[7:0] == latched_count_reg[15:8]) begin
            wave_next = 1'b0;
          end
        end
      end
      default: begin
        count_next = count_reg;
      end
    endcase
    if (restart)
      count_next = `CCT_RST_COUNT;
  end
end

// bus write decode
wire do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
wire wr_ok = do_write & mapped(aw_idx_reg);
wire [15:0] wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
wire [15:0] wval = wdata_reg[15:0];
wire wr_cnt = wr_ok && aw_idx_reg == `CCT_IDX_COUNT;
wire wr_lat = wr_ok && aw_idx_reg == `CCT_IDX_LATCH;
wire wr_flag = wr_ok && aw_idx_reg == `CCT_IDX_IRQ_FLAG && wstrb_reg[0];
wire ar_hs = s_axi_arvalid & ~rvalid_reg;
wire [3:0] ar_idx = idx_of(s_axi_araddr);
wire sample_trigger_mode = (mode >= `CCT_M_SAMPLE_TRIGGER) && (mode <= `CCT_M_FRQPW);
wire rd_lat = ar_hs && ar_idx == `CCT_IDX_LATCH && sample_trigger_mode;
wire [1:0] clr = (wr_flag ? wdata_reg[1:0] : 2'h0) |
                 {1'b0, rd_lat};
wire [1:0] setv = {set_wrap, set_sample_trigger};

// registers and timer state
always @(posedge aclk) begin
  if (!aresetn) begin
    ctrl_a_reg <= `CCT_RST_CTRL;
    ctrl_b_reg <= `CCT_RST_CTRL;
    ev_ctrl_reg <= `CCT_RST_CTRL;
    irq_enable_reg <= `CCT_RST_FLAGS;
    irq_flag_reg <= `CCT_RST_FLAGS;
    count_reg <= `CCT_RST_COUNT;
    latched_count_reg <= `CCT_RST_COUNT;
    running_reg <= 1'b0;
    wave_reg <= 1'b0;
    phase_reg <= 1'b0;
    div2_reg <= 1'b0;
    trig_rise_d_reg <= 1'b0;
    trig_fall_d_reg <= 1'b0;
    sample_trigger_ev_reg <= 1'b0;
    wrap_ev_reg <= 1'b0;
  end else begin
    div2_reg <= active & ~div2_reg;
    trig_rise_d_reg <= t_rise;
    trig_fall_d_reg <= t_fall;
    sample_trigger_ev_reg <= set_sample_trigger;
    wrap_ev_reg <= set_wrap;
    running_reg <= running_next;
    phase_reg <= phase_next;
    if (mode == `CCT_M_SINGLE || mode == `CCT_M_PWM8)
      wave_reg <= wave_next;
    else
      wave_reg <= ctrl_b_reg[`CCT_B_OUT_INIT];
    // set wins over clear; flag ignores its enable
    irq_flag_reg <= (irq_flag_reg & ~clr) | setv;
    if (wr_cnt)
      count_reg <= (count_next & ~wmask) | (wval & wmask);
    else
      count_reg <= count_next;
    if (wr_lat && !set_sample_trigger)
      latched_count_reg <= (latched_count_reg & ~wmask) | (wval & wmask);
    else
      latched_count_reg <= latch_next;
    if (wr_ok && wstrb_reg[0]) begin
      case (aw_idx_reg)
        `CCT_IDX_CTRL_A: ctrl_a_reg <= wdata_reg[6:0];
        `CCT_IDX_CTRL_B: ctrl_b_reg <= wdata_reg[6:0];
        `CCT_IDX_EV_CTRL: ev_ctrl_reg <= wdata_reg[6:0];
        `CCT_IDX_IRQ_EN: irq_enable_reg <= wdata_reg[1:0];
        default: ctrl_a_reg <= ctrl_a_reg;
      endcase
    end
  end
end

// read data mux
reg [31:0] rd_word;
always @* begin
  rd_word = 32'h00000000;
  case (ar_idx)
    `CCT_IDX_CTRL_A: rd_word[6:0] = ctrl_a_reg;
    `CCT_IDX_CTRL_B: rd_word[6:0] = ctrl_b_reg;
    `CCT_IDX_EV_CTRL: rd_word[6:0] = ev_ctrl_reg;
    `CCT_IDX_IRQ_EN: rd_word[1:0] = irq_enable_reg;
    `CCT_IDX_IRQ_FLAG: rd_word[1:0] = irq_flag_reg;
    `CCT_IDX_STATUS: rd_word[0] = active & run_eff;
    `CCT_IDX_COUNT: rd_word[15:0] = count_reg;
    `CCT_IDX_LATCH: rd_word[15:0] = latched_count_reg;
    default: rd_word = 32'h00000000;
  endcase
end

// axi4-lite channel handshakes
always @(posedge aclk) begin
  if (!aresetn) begin
    aw_got_reg <= 1'b0;
    w_got_reg <= 1'b0;
    aw_idx_reg <= 4'h0;
    wdata_reg <= 32'h00000000;
    wstrb_reg <= 4'h0;
    bvalid_reg <= 1'b0;
    bresp_reg <= `CCT_RESP_OKAY;
    rvalid_reg <= 1'b0;
    rdata_reg <= 32'h00000000;
    rresp_reg <= `CCT_RESP_OKAY;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      aw_idx_reg <= idx_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    if (do_write) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg <= mapped(aw_idx_reg) ? `CCT_RESP_OKAY :
                   `CCT_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
    if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= mapped(ar_idx) ? `CCT_RESP_OKAY : `CCT_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
end

assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
assign s_axi_wready = ~w_got_reg & ~bvalid_reg;
assign s_axi_bvalid = bvalid_reg;
assign s_axi_bresp = bresp_reg;
assign s_axi_arready = ~rvalid_reg;
assign s_axi_rvalid = rvalid_reg;
assign s_axi_rdata = rdata_reg;
assign s_axi_rresp = rresp_reg;

assign sample_trigger_event_out = sample_trigger_ev_reg;
assign wrap_event_out = wrap_ev_reg;
assign irq_out = |(irq_flag_reg & irq_enable_reg);
assign wave_out = wave_reg;
assign wave_oe = ctrl_b_reg[`CCT_B_OUT_EN];

endmodule // cct_timer

// file: testbench/cct_timer_props.sv
// Purpose: port checker for the cascadable capture timer
// Assumes: one clock aclk; aresetn synchronous, active low
// Notes: bound to cct_timer after the module
module cct_timer_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // events, sleep, interrupt
  input wire sample_trigger_event_out,
  input wire wrap_event_out,
  input wire powerdown_sleep,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_sample_trigger_one_cycle: assert property (sample_trigger_event_out |=> !sample_trigger_event_out)
    else $error("capture event longer than one cycle");
  a_wrap_one_cycle: assert property (wrap_event_out |=> !wrap_event_out)
    else $error("wrap event longer than one cycle");
  a_irq_rise_cause: assert property ($rose(irq_out) |->
    sample_trigger_event_out || wrap_event_out || $rose(s_axi_bvalid))
    else $error("interrupt rose without flag or enable change");
  a_irq_held_set: assert property ($fell(irq_out) |->
    $rose(s_axi_bvalid) || s_axi_rvalid || $past(s_axi_rvalid))
    else $error("interrupt dropped without software access");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read response late");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response not released");
  a_rdat_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("read data not released");
  a_aw_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_pd_silent: assert property ($past(powerdown_sleep) &&
    $past(powerdown_sleep, 2) |-> !sample_trigger_event_out && !wrap_event_out)
    else $error("event emitted in power-down");
  c_sample_trigger: cover property (sample_trigger_event_out);
  c_wrap: cover property (wrap_event_out);
  c_irq: cover property ($rose(irq_out));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // cct_timer_props

bind cct_timer cct_timer_props i_cct_timer_props (.*);

// file: testbench/cct_evnet_model.sv
// Purpose: event network and companion type-A timer model
// Assumes: lines except the 20 ns glitch are same-clock; all change after a rising edge
// Notes: tasks are called by the bench
module cct_evnet_model (
  // clock
  input wire aclk,
  // event and companion lines
  output logic trig_event_in,
  output logic count_event_in,
  output logic [1:0] companion_tick,
  output logic [1:0] companion_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    trig_event_in = 1'b0;
    count_event_in = 1'b0;
    companion_tick = 2'h0;
    companion_restart = 2'h0;
  end
  task automatic set_trig(input logic v);
    @(posedge aclk);
    trig_event_in <= v;
  endtask
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge aclk);
      count_event_in <= 1'b1;
      repeat (2) @(posedge aclk);
      count_event_in <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task automatic ticks(input int k, input int n);
    repeat (n) begin
      @(posedge aclk);
      companion_tick[k] <= 1'b1;
      @(posedge aclk);
      companion_tick[k] <= 1'b0;
    end
  endtask
  task automatic glitch;
    @(posedge aclk);
    trig_event_in <= 1'b1;
    #20 trig_event_in <= 1'b0;
  endtask
  task automatic restart_pulse(input int k);
    @(posedge aclk);
    companion_restart[k] <= 1'b1;
    @(posedge aclk);
    companion_restart[k] <= 1'b0;
  endtask
endmodule // cct_evnet_model

// file: testbench/tb.sv
// Purpose: self-checking bench for the cascadable capture timer
// Assumes: 20 MHz aclk; registers at byte address four times index
// Notes: bus outputs are sampled at the falling edge before use
`include "cct_timer_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, standby_sleep, powerdown_sleep;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, sample_trigger_event_out, wrap_event_out;
  wire irq_out, wave_out, wave_oe, trig_event_in, count_event_in;
  wire [1:0] s_axi_bresp, s_axi_rresp, companion_tick, companion_restart;
  wire [31:0] s_axi_rdata;
  logic [1:0] r;
  int fails, checks_done, b, f, c;
  cct_timer i_cct_timer (.*);
  cct_evnet_model i_cct_evnet_model (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  function automatic logic [5:0] ad(input logic [3:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [31:0] ctla(input logic [2:0] s, x);
    return {25'h0, x, s, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic wa, ww, h;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge aclk);
      wa = s_axi_awvalid && s_axi_awready;
      ww = s_axi_wvalid && s_axi_wready;
      h = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (wa) s_axi_awvalid <= 1'b0;
      if (ww) s_axi_wvalid <= 1'b0;
      if (h) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [5:0] a);
    logic ta, h;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      h = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (h) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk({31'h0, irq_out}, {31'h0, e});
  endtask
  task automatic lat(output int n);
    n = 0;
    i_cct_evnet_model.set_trig(1'b1);
    @(negedge aclk);
    while (!sample_trigger_event_out && n < 30) begin
      n++;
      @(negedge aclk);
    end
    i_cct_evnet_model.set_trig(1'b0);
    repeat (12) @(posedge aclk);
    wr(ad(`CCT_IDX_IRQ_FLAG), 32'h3);
  endtask
  task automatic t_regs;
    rd(ad(`CCT_IDX_CTRL_A));
    chk(d, 32'h0);
    wr(ad(`CCT_IDX_CTRL_B), {29'h0, `CCT_M_SAMPLE_TRIGGER});
    rd(ad(`CCT_IDX_CTRL_B));
    chk(d, 32'h2);
    s_axi_wstrb <= 4'h1;
    wr(ad(`CCT_IDX_COUNT), 32'hABCD);
    rd(ad(`CCT_IDX_COUNT));
    chk(d, 32'hCD);
    s_axi_wstrb <= 4'hE;
    wr(ad(`CCT_IDX_CTRL_B), 32'h7);
    rd(ad(`CCT_IDX_CTRL_B));
    chk(d, 32'h2);
    s_axi_wstrb <= 4'hF;
    wr(6'h08, 32'h1);
    chk({30'h0, r}, {30'h0, `CCT_RESP_SLVERR});
    rd(6'h08);
    chk({30'h0, r}, {30'h0, `CCT_RESP_SLVERR});
    chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_capture;
    wr(ad(`CCT_IDX_EV_CTRL), 32'h0);
    wr(ad(`CCT_IDX_CTRL_A), ctla(3'h4, 3'h0));
    wr(ad(`CCT_IDX_COUNT), 32'h1234);
    lat(b);
    rd(ad(`CCT_IDX_IRQ_FLAG));
    chk(d, 32'h0);
    wr(ad(`CCT_IDX_EV_CTRL), 32'h1);
    i_cct_evnet_model.set_trig(1'b1);
    repeat (8) @(posedge aclk);
    i_cct_evnet_model.set_trig(1'b0);
    rd(ad(`CCT_IDX_IRQ_FLAG));
    chk(d, 32'h1);
    chk_irq(1'b0);
    wr(ad(`CCT_IDX_IRQ_EN), 32'h1);
    chk_irq(1'b1);
    wr(ad(`CCT_IDX_IRQ_FLAG), 32'h1);
    chk_irq(1'b0);
    rd(ad(`CCT_IDX_LATCH));
    chk(d, 32'h1234);
    $display("test capture done");
  endtask
  task automatic t_filter;
    lat(b);
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_DIV2, 3'h0));
    wr(ad(`CCT_IDX_EV_CTRL), 32'h41);
    lat(f);
    chk(f - b, 32'd4);
    i_cct_evnet_model.set_trig(1'b1);
    repeat (2) @(posedge aclk);
    i_cct_evnet_model.set_trig(1'b0);
    repeat (12) @(posedge aclk);
    rd(ad(`CCT_IDX_IRQ_FLAG));
    chk(d & 32'h1, 32'h0);
    wr(ad(`CCT_IDX_EV_CTRL), 32'h1);
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_EVENT, 3'h2));
    lat(c);
    chk(c - b, 32'd1);
    $display("test filter done");
  endtask
  task automatic t_wrap;
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_DIV1, 3'h0));
    wr(ad(`CCT_IDX_COUNT), 32'hFFF0);
    b = 0;
    while (!wrap_event_out && b < 40) begin
      @(negedge aclk);
      b++;
    end
    chk({31'h0, wrap_event_out}, 32'h1);
    rd(ad(`CCT_IDX_IRQ_FLAG));
    chk(d & 32'h2, 32'h2);
    rd(ad(`CCT_IDX_COUNT));
    chk({31'h0, d < 32'h40}, 32'h1);
    $display("test wrap done");
  endtask
  task automatic cnt_chk(input logic [2:0] s, x, input int n);
    wr(ad(`CCT_IDX_CTRL_A), ctla(s, x));
    i_cct_evnet_model.pulse_count(n);
    repeat (6) @(posedge aclk);
    rd(ad(`CCT_IDX_COUNT));
  endtask
  task automatic t_count;
    wr(ad(`CCT_IDX_CTRL_A), 32'h0);
    wr(ad(`CCT_IDX_COUNT), 32'h0);
    cnt_chk(`CCT_CLK_EVENT, 3'h0, 3);
    chk(d, 32'h3);
    cnt_chk(3'h4, 3'h0, 2);
    chk(d, 32'h3);
    standby_sleep <= 1'b1;
    cnt_chk(`CCT_CLK_EVENT, 3'h0, 2);
    chk(d, 32'h3);
    cnt_chk(`CCT_CLK_EVENT, 3'h4, 2);
    chk(d, 32'h5);
    powerdown_sleep <= 1'b1;
    cnt_chk(`CCT_CLK_EVENT, 3'h4, 2);
    chk(d, 32'h5);
    standby_sleep <= 1'b0;
    powerdown_sleep <= 1'b0;
    $display("test count done");
  endtask
  task automatic t_companion;
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_CMP0, 3'h0));
    wr(ad(`CCT_IDX_COUNT), 32'h0);
    i_cct_evnet_model.ticks(0, 5);
    i_cct_evnet_model.ticks(1, 3);
    rd(ad(`CCT_IDX_COUNT));
    chk(d, 32'h5);
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_CMP1, 3'h1));
    i_cct_evnet_model.ticks(1, 2);
    i_cct_evnet_model.restart_pulse(0);
    rd(ad(`CCT_IDX_COUNT));
    chk(d, 32'h7);
    i_cct_evnet_model.restart_pulse(1);
    rd(ad(`CCT_IDX_COUNT));
    chk(d, 32'h0);
    $display("test companion done");
  endtask
  task automatic t_single;
    wr(ad(`CCT_IDX_LATCH), 32'h8);
    wr(ad(`CCT_IDX_CTRL_B), {25'h0, 3'h5, 1'b0, `CCT_M_SINGLE});
    wr(ad(`CCT_IDX_CTRL_A), ctla(`CCT_CLK_DIV1, 3'h0));
    i_cct_evnet_model.glitch;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk({30'h0, wave_oe, wave_out}, 32'h3);
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    chk({30'h0, wave_oe, wave_out}, 32'h2);
    rd(ad(`CCT_IDX_IRQ_FLAG));
    chk(d & 32'h1, 32'h1);
    $display("test single done");
  endtask
  task automatic final_report;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    fails++;
    final_report;
  end
  initial begin
    aresetn = 1'b0;
    standby_sleep = 1'b0;
    powerdown_sleep = 1'b0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_regs;
    t_capture;
    t_filter;
    t_wrap;
    t_count;
    t_companion;
    t_single;
    final_report;
  end
endmodule // tb
